// *** hdl/dbv_supervisor.sv ***
// DC bus voltage supervisor with its parameter registers and fault flags.
`timescale 1ns/1ps

// Notes on behaviour
// - Over-voltage fault level is read-only, 16 bit.
// - Over-voltage fault level comes from EEPROM.
// - Warning level writable, 0..900, zero disables.
// - Warn while bus voltage exceeds nonzero level.
// - Capacitor load limit is read-only, 8 bit.
// - Load above limit raises capacitor overload fault once the EEPROM load has been done.
// - Under-voltage level accepts 90..420, default 90.
// - Under-voltage default from EEPROM, user writable, saveable.
// - Mode 0 always faults; mode 1 only on enable.
// - Measured bus voltage readable, compared against thresholds.
module dbv_supervisor
  import dbv_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [15:0] VBUS_SAMPLE_IN,
  input wire logic VBUS_VALID_IN,
  input wire logic [7:0] CAP_LOAD_IN,
  input wire logic CAP_VALID_IN,
  input wire logic ENABLE_REQ_IN,
  input wire logic EE_LOAD_IN,
  input wire logic [15:0] EE_OVF_LEVEL_IN,
  input wire logic [15:0] EE_UVF_LEVEL_IN,
  input wire logic [7:0] EE_CAP_LIMIT_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [15:0] WR_DATA_IN,
  output logic [15:0] RD_DATA_OUT,
  output logic RD_VALID_OUT,
  output logic NV_SAVE_OUT,
  output logic [15:0] NV_DATA_OUT,
  output logic OV_WARN_OUT,
  output logic UV_FAULT_OUT,
  output logic CAP_FAULT_OUT,
  output logic OV_FAULT_OUT
);

  // ---------------------------------------------------------------------------
  // Registers and decode.
  // ---------------------------------------------------------------------------
  logic [15:0] ovf_level_r;
  logic [15:0] ovw_level_r;
  logic [7:0] cap_limit_r;
  logic [15:0] uvf_level_r;
  logic uv_mode_r;
  logic [15:0] vbus_r;
  logic ee_valid_r;
  logic wr_ovw;
  logic wr_uvf;
  logic wr_mode;
  logic wr_flags;
  logic [3:0] clr_bits;

  // Write strobes; out-of-range values are dropped rather than clamped.
  assign wr_ovw = WR_IN && (ADDR_IN == OVW_LEVEL_ADDR) && (WR_DATA_IN <= VOLT_MAX);
  assign wr_uvf = WR_IN && (ADDR_IN == UVF_LEVEL_ADDR) && (WR_DATA_IN >= UVF_MIN)
    && (WR_DATA_IN <= UVF_MAX);
  assign wr_mode = WR_IN && (ADDR_IN == UV_MODE_ADDR);
  assign wr_flags = WR_IN && (ADDR_IN == FLAGS_ADDR);
  assign clr_bits = wr_flags ? WR_DATA_IN[3:0] : 4'h0;

  // The fault level and capacitor limit change only on an EEPROM load.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ovf_level_r <= 16'h0000;
      cap_limit_r <= 8'h00;
      ee_valid_r <= 1'b0;
    end else if (EE_LOAD_IN) begin
      ovf_level_r <= EE_OVF_LEVEL_IN;
      cap_limit_r <= EE_CAP_LIMIT_IN;
      ee_valid_r <= 1'b1;
    end
  end

  // Warning level, user writable only.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ovw_level_r <= OVW_LEVEL_RST;
    end else if (wr_ovw) begin
      ovw_level_r <= WR_DATA_IN;
    end
  end

  // Under-voltage level: a user write wins over an EEPROM default load.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      uvf_level_r <= UVF_LEVEL_RST;
    end else if (wr_uvf) begin
      uvf_level_r <= WR_DATA_IN;
    end else if (EE_LOAD_IN) begin
      uvf_level_r <= EE_UVF_LEVEL_IN;
    end
  end

  // Under-voltage fault mode.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      uv_mode_r <= UV_MODE_RST;
    end else if (wr_mode) begin
      uv_mode_r <= WR_DATA_IN[0];
    end
  end

  // A save write hands the current under-voltage level to the NV store.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      NV_SAVE_OUT <= 1'b0;
      NV_DATA_OUT <= 16'h0000;
    end else begin
      NV_SAVE_OUT <= WR_IN && (ADDR_IN == NV_SAVE_ADDR);
      if (WR_IN && (ADDR_IN == NV_SAVE_ADDR)) begin
        NV_DATA_OUT <= uvf_level_r;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Comparison and flags.
  // ---------------------------------------------------------------------------
  logic ov_warn_hit;
  logic uv_hit;
  logic cap_hit;
  logic ov_hit;

  // Comparisons use the fresh sample, so flags lag it by exactly one edge.
  assign ov_warn_hit = (ovw_level_r != 16'h0000) && (VBUS_SAMPLE_IN > ovw_level_r);
  assign uv_hit = (VBUS_SAMPLE_IN < uvf_level_r) && (!uv_mode_r || ENABLE_REQ_IN);
  assign cap_hit = CAP_VALID_IN && ee_valid_r && (CAP_LOAD_IN > cap_limit_r);
  // Before the EEPROM load the fault level is unknown, so no fault is raised.
  assign ov_hit = ee_valid_r && (VBUS_SAMPLE_IN > ovf_level_r);

  // Latest sample kept for read-back.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      vbus_r <= 16'h0000;
    end else if (VBUS_VALID_IN) begin
      vbus_r <= VBUS_SAMPLE_IN;
    end
  end

  // Warning tracks each sample and holds between samples.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      OV_WARN_OUT <= 1'b0;
    end else if (VBUS_VALID_IN) begin
      OV_WARN_OUT <= ov_warn_hit;
    end
  end

  // Sticky faults; a new hit in the clearing cycle keeps the flag set.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      UV_FAULT_OUT <= 1'b0;
      CAP_FAULT_OUT <= 1'b0;
      OV_FAULT_OUT <= 1'b0;
    end else begin
      UV_FAULT_OUT <= (VBUS_VALID_IN && uv_hit)
        || (UV_FAULT_OUT && !clr_bits[FLAG_UV_FAULT]);
      CAP_FAULT_OUT <= cap_hit || (CAP_FAULT_OUT && !clr_bits[FLAG_CAP_FAULT]);
      OV_FAULT_OUT <= (VBUS_VALID_IN && ov_hit)
        || (OV_FAULT_OUT && !clr_bits[FLAG_OV_FAULT]);
    end
  end

  // ---------------------------------------------------------------------------
  // Read port: data one edge after the strobe, unmapped reads return zero.
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RD_DATA_OUT <= 16'h0000;
      RD_VALID_OUT <= 1'b0;
    end else begin
      RD_VALID_OUT <= RD_IN;
      if (RD_IN) begin
        case (ADDR_IN)
          OVF_LEVEL_ADDR: RD_DATA_OUT <= ovf_level_r;
          OVW_LEVEL_ADDR: RD_DATA_OUT <= ovw_level_r;
          CAP_LIMIT_ADDR: RD_DATA_OUT <= {8'h00, cap_limit_r};
          UVF_LEVEL_ADDR: RD_DATA_OUT <= uvf_level_r;
          UV_MODE_ADDR: RD_DATA_OUT <= {15'h0000, uv_mode_r};
          VBUS_READ_ADDR: RD_DATA_OUT <= vbus_r;
          FLAGS_ADDR: RD_DATA_OUT <= {12'h000, OV_FAULT_OUT, CAP_FAULT_OUT, UV_FAULT_OUT,
            OV_WARN_OUT};
          default: RD_DATA_OUT <= 16'h0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking dbv_cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  ovf_read_only_a: assert property (
    (WR_IN && !EE_LOAD_IN) |=> $stable(ovf_level_r))
    else $error("fault level changed without an EEPROM load");
  ovf_ee_load_a: assert property (
    EE_LOAD_IN |=> (ovf_level_r == $past(EE_OVF_LEVEL_IN)))
    else $error("fault level not taken from EEPROM");
  ovw_disabled_a: assert property (
    (VBUS_VALID_IN && (ovw_level_r == 16'h0000)) |=> !OV_WARN_OUT)
    else $error("warning raised with level zero");
  ovw_warning_a: assert property (
    (VBUS_VALID_IN && (ovw_level_r != 16'h0000) && (VBUS_SAMPLE_IN > ovw_level_r))
      |=> OV_WARN_OUT ##1 (OV_WARN_OUT || $past(VBUS_VALID_IN)))
    else $error("over-voltage warning missed");
  cap_limit_ro_a: assert property (
    !EE_LOAD_IN |=> $stable(cap_limit_r))
    else $error("capacitor limit changed");
  cap_fault_a: assert property (
    cap_hit |=> CAP_FAULT_OUT)
    else $error("capacitor overload fault missed");
  uvf_range_a: assert property (
    (WR_IN && (ADDR_IN == UVF_LEVEL_ADDR) && !EE_LOAD_IN
      && ((WR_DATA_IN < UVF_MIN) || (WR_DATA_IN > UVF_MAX))) |=> $stable(uvf_level_r))
    else $error("out-of-range under-voltage level accepted");
  nv_save_a: assert property (
    (WR_IN && (ADDR_IN == NV_SAVE_ADDR)) |=> (NV_SAVE_OUT && (NV_DATA_OUT == $past(uvf_level_r))))
    else $error("NV save not issued");
  uv_mode_a: assert property (
    (VBUS_VALID_IN && (VBUS_SAMPLE_IN < uvf_level_r) && uv_mode_r && !ENABLE_REQ_IN
      && !UV_FAULT_OUT) |=> !UV_FAULT_OUT)
    else $error("under-voltage fault in mode 1 without enable");
  vbus_read_a: assert property (
    (RD_IN && (ADDR_IN == VBUS_READ_ADDR)) |=> (RD_VALID_OUT && (RD_DATA_OUT == $past(vbus_r))))
    else $error("bus voltage read-back wrong");
  uv_fault_a: assert property (
    (VBUS_VALID_IN && (VBUS_SAMPLE_IN < uvf_level_r) && !uv_mode_r) |=> UV_FAULT_OUT)
    else $error("under-voltage fault in mode 0 missed");
  fault_latch_a: assert property (
    (OV_FAULT_OUT && !clr_bits[FLAG_OV_FAULT]) |=> OV_FAULT_OUT [*1])
    else $error("over-voltage fault dropped without a clear");

endmodule

// *** hdl/dbv_pkg.sv ***
// Package of register offsets, field positions, reset values and limits of the bus supervisor.
package dbv_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets on the parameter port.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OVF_LEVEL_ADDR = 16'h031a;
  localparam logic [15:0] OVW_LEVEL_ADDR = 16'h031c;
  localparam logic [15:0] CAP_LIMIT_ADDR = 16'h031e;
  localparam logic [15:0] UVF_LEVEL_ADDR = 16'h0320;
  localparam logic [15:0] UV_MODE_ADDR = 16'h0322;
  localparam logic [15:0] VBUS_READ_ADDR = 16'h0326;
  localparam logic [15:0] FLAGS_ADDR = 16'h0330;
  localparam logic [15:0] NV_SAVE_ADDR = 16'h0332;

  // ---------------------------------------------------------------------------
  // Flag register bit positions; faults are cleared by writing one.
  // ---------------------------------------------------------------------------
  localparam int FLAG_OV_WARN = 0;
  localparam int FLAG_UV_FAULT = 1;
  localparam int FLAG_CAP_FAULT = 2;
  localparam int FLAG_OV_FAULT = 3;

  // ---------------------------------------------------------------------------
  // Reset values and accepted ranges, in volts.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OVW_LEVEL_RST = 16'h0000;
  localparam logic [15:0] UVF_LEVEL_RST = 16'h005a;
  localparam logic UV_MODE_RST = 1'h1;
  localparam logic [15:0] VOLT_MAX = 16'h0384;
  localparam logic [15:0] UVF_MIN = 16'h005a;
  localparam logic [15:0] UVF_MAX = 16'h01a4;
endpackage

// *** tb/dbv_supervisor_tb.sv ***
// Self-checking bench of the DC bus voltage supervisor.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module dbv_supervisor_tb;
  import dbv_pkg::*;
  logic clk = 0, rst_n = 0, vv = 0, cv = 0, en = 0, ee = 0, wr = 0, rd = 0;
  logic [15:0] vs = 0, addr = 0, wdat = 0, rdat, nvd;
  logic [7:0] cl = 0;
  logic rv, nvs, warn, uvf, capf, ovf;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  // ---------------------------------------------------------------------------
  // Clock, device and hang guard.
  // ---------------------------------------------------------------------------
  always #4 clk = ~clk;
  dbv_supervisor dbv_supervisor_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .VBUS_SAMPLE_IN(vs),
    .VBUS_VALID_IN(vv), .CAP_LOAD_IN(cl), .CAP_VALID_IN(cv), .ENABLE_REQ_IN(en),
    .EE_LOAD_IN(ee), .EE_OVF_LEVEL_IN(16'h0320), .EE_UVF_LEVEL_IN(16'h0064),
    .EE_CAP_LIMIT_IN(8'h32), .ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd), .WR_DATA_IN(wdat),
    .RD_DATA_OUT(rdat), .RD_VALID_OUT(rv), .NV_SAVE_OUT(nvs), .NV_DATA_OUT(nvd),
    .OV_WARN_OUT(warn), .UV_FAULT_OUT(uvf), .CAP_FAULT_OUT(capf), .OV_FAULT_OUT(ovf));
  // The ceiling sits well above the fewer than a hundred cycles the tests need.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      close_out();
    end
  end
  // ---------------------------------------------------------------------------
  // Bus and sample tasks; each starts with an idle edge so no strobe is set twice.
  // ---------------------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    tick();
    addr = a;
    wdat = d;
    wr = 1;
    tick();
    wr = 0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    tick();
    addr = a;
    rd = 1;
    tick();
    rd = 0;
    `CHK("read valid", 1'b1, rv)
    `CHK("read data", e, rdat)
  endtask
  task automatic smp(input logic [15:0] v, input logic e);
    tick();
    vs = v;
    en = e;
    vv = 1;
    tick();
    vv = 0;
  endtask
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    rd_chk(OVW_LEVEL_ADDR, 16'h0000);
    rd_chk(UVF_LEVEL_ADDR, 16'h005a);
    rd_chk(16'h0400, 16'h0000);
    // Before the EEPROM load the fault level reads zero, so only the gate keeps this quiet.
    smp(16'h0384, 0);
    `CHK("ov gated", 1'b0, ovf)
    tick();
    ee = 1;
    tick();
    ee = 0;
    wr_reg(OVF_LEVEL_ADDR, 16'h0010);
    wr_reg(CAP_LIMIT_ADDR, 16'h0001);
    rd_chk(OVF_LEVEL_ADDR, 16'h0320);
    rd_chk(CAP_LIMIT_ADDR, 16'h0032);
    rd_chk(UVF_LEVEL_ADDR, 16'h0064);
    wr_reg(UVF_LEVEL_ADDR, 16'h01a4);
    wr_reg(UVF_LEVEL_ADDR, 16'h01a5);
    wr_reg(UVF_LEVEL_ADDR, 16'h0059);
    rd_chk(UVF_LEVEL_ADDR, 16'h01a4);
    wr_reg(NV_SAVE_ADDR, 16'h0000);
    `CHK("save pulse", 1'b1, nvs)
    `CHK("save data", 16'h01a4, nvd)
    $display("registers and save done");
  endtask
  // Warning follows the latest sample and stays off while the level is zero.
  task automatic t_warn();
    smp(16'h01f4, 0);
    `CHK("warn off", 1'b0, warn)
    wr_reg(OVW_LEVEL_ADDR, 16'h0385);
    wr_reg(OVW_LEVEL_ADDR, 16'h0258);
    rd_chk(OVW_LEVEL_ADDR, 16'h0258);
    smp(16'h0258, 0);
    `CHK("warn equal", 1'b0, warn)
    smp(16'h0259, 0);
    `CHK("warn above", 1'b1, warn)
    smp(16'h0257, 0);
    `CHK("warn drop", 1'b0, warn)
    rd_chk(VBUS_READ_ADDR, 16'h0257);
    $display("warning done");
  endtask
  // Faults latch through good samples and clear only by a write of one.
  task automatic t_faults();
    wr_reg(UVF_LEVEL_ADDR, 16'h0064);
    wr_reg(UV_MODE_ADDR, 16'h0000);
    smp(16'h0063, 0);
    `CHK("uv mode0", 1'b1, uvf)
    smp(16'h00c8, 0);
    `CHK("uv latched", 1'b1, uvf)
    wr_reg(FLAGS_ADDR, 16'h0002);
    `CHK("uv cleared", 1'b0, uvf)
    wr_reg(UV_MODE_ADDR, 16'h0001);
    smp(16'h0032, 0);
    `CHK("uv mode1 idle", 1'b0, uvf)
    smp(16'h0032, 1);
    `CHK("uv mode1 enable", 1'b1, uvf)
    tick();
    cl = 8'h32;
    cv = 1;
    tick();
    `CHK("cap at limit", 1'b0, capf)
    cl = 8'h33;
    tick();
    cv = 0;
    `CHK("cap over", 1'b1, capf)
    wr_reg(FLAGS_ADDR, 16'h0004);
    `CHK("cap cleared", 1'b0, capf)
    `CHK("uv kept", 1'b1, uvf)
    smp(16'h0321, 0);
    `CHK("ov fault", 1'b1, ovf)
    rd_chk(FLAGS_ADDR, 16'h000b);
    rd_chk(UV_MODE_ADDR, 16'h0001);
    // A clear that meets a fresh hit on the same edge must leave the fault set.
    tick();
    addr = FLAGS_ADDR;
    wdat = 16'h0008;
    wr = 1;
    vv = 1;
    tick();
    wr = 0;
    vv = 0;
    `CHK("ov set wins", 1'b1, ovf)
    wr_reg(FLAGS_ADDR, 16'h0008);
    `CHK("ov cleared", 1'b0, ovf)
    $display("faults done");
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    t_regs();
    t_warn();
    t_faults();
    close_out();
  end
endmodule
